// ### include/ovfr_pkg.sv
// package for the output over-voltage fault reaction block
// assumes a register write strobe from the PMBus command decoder outside
package ovfr_pkg;
   localparam logic [7:0] OVFR_REACTION_CFG_ADDR = 8'h41;
   localparam logic [7:0] OVFR_TRIP_THRESHOLD_ADDR = 8'h40;
   localparam logic [7:0] OVFR_DELAY_UNIT_ADDR = 8'hc8;
   localparam logic [7:0] OVFR_REACTION_CFG_RESET = 8'h80;
   localparam logic [15:0] OVFR_TRIP_THRESHOLD_RESET = 16'hffff;
   localparam logic [15:0] OVFR_DELAY_UNIT_RESET = 16'h0001;
   localparam int OVFR_RESP_MSB = 7;
   localparam int OVFR_RESP_LSB = 6;
   localparam int OVFR_RETRY_MSB = 5;
   localparam int OVFR_RETRY_LSB = 3;
   localparam int OVFR_DELAY_MSB = 2;
   localparam int OVFR_DELAY_LSB = 0;
   localparam logic [1:0] OVFR_RESP_IGNORE = 2'h0;
   localparam logic [1:0] OVFR_RESP_DELAY = 2'h1;
   localparam logic [1:0] OVFR_RESP_SHUTDOWN = 2'h2;
   localparam logic [1:0] OVFR_RESP_WHILE = 2'h3;
   localparam logic [2:0] OVFR_RETRY_NONE = 3'h0;
   localparam logic [2:0] OVFR_RETRY_FOREVER = 3'h7;
   localparam int OVFR_TIMER_W = 24;

   typedef enum logic [2:0] {
      OVFR_RUN      = 3'b000,
      OVFR_GRACE    = 3'b001,
      OVFR_WAIT     = 3'b011,
      OVFR_RESTART  = 3'b010,
      OVFR_LATCHED  = 3'b110,
      OVFR_HOLD     = 3'b111
   } ovfr_state_t;
endpackage

// ### design/ovfr_core.sv
// output over-voltage fault reaction: compare, grace delay, shutdown, retries
// assumes synchronous inputs, register writes as one-cycle strobes with address
`timescale 1ns/1ps
// Function
// - code 00 keeps converting through faults
// - code 01 runs for delay, then retry
// - code 10 disables at once, then retry
// - code 11 disables only while fault persists
// - status clear, clear-faults, reset, bias clear
// - output off then on clears fault
// - retry 000 stays off until cleared
// - retry 1..6 attempts, then stay off
// - attempts spaced by delay times unit
// - retry 111 retries without limit
// - delay field n means 2^n units
// - unit register shared by both delays
// - fault when voltage exceeds trip threshold
module ovfr_core
   import ovfr_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   input  wire logic        clk_en,
   input  wire logic        reg_wr,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic [15:0] vout_meas,
   input  wire logic        status_bit_clr,
   input  wire logic        clear_faults_cmd,
   input  wire logic        bias_lost,
   input  wire logic        output_cmd_on,
   input  wire logic        other_fault_shutdown,
   output logic             output_enable,
   output logic             fault_latched,
   output logic             ov_fault,
   output logic [7:0]       reaction_cfg_rd,
   output logic [2:0]       state_rd
);
   logic [7:0]              cfg_q;
   logic [15:0]             thr_q;
   logic [15:0]             unit_q;
   ovfr_state_t             st_q;
   logic [OVFR_TIMER_W-1:0] tmr_q;
   logic [2:0]              tries_q;
   logic                    cmd_on_q;
   logic                    clr_any;
   logic                    ov_now;
   logic [1:0]              resp;
   logic [2:0]              retry;
   logic [2:0]              dly;

   // 2^n units; 128 * 16-bit unit fits the 24-bit timer
   // a zero unit wraps the load to the longest count, so hosts must not write it
   function automatic logic [OVFR_TIMER_W-1:0] delay_cycles(input logic [2:0] n,
                                                             input logic [15:0] u);
      delay_cycles = {8'h00, u} << n;
   endfunction

   assign resp   = cfg_q[OVFR_RESP_MSB:OVFR_RESP_LSB];
   assign retry  = cfg_q[OVFR_RETRY_MSB:OVFR_RETRY_LSB];
   assign dly    = cfg_q[OVFR_DELAY_MSB:OVFR_DELAY_LSB];
   assign ov_now = vout_meas > thr_q;
   // commanded off-to-on edge acts as a clear
   assign clr_any = status_bit_clr | clear_faults_cmd | bias_lost
                  | (output_cmd_on & ~cmd_on_q);

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cfg_q  <= OVFR_REACTION_CFG_RESET;
         thr_q  <= OVFR_TRIP_THRESHOLD_RESET;
         unit_q <= OVFR_DELAY_UNIT_RESET;
      end else if (clk_en && reg_wr) begin
         if (reg_addr == OVFR_REACTION_CFG_ADDR) cfg_q <= reg_wdata[7:0];
         if (reg_addr == OVFR_TRIP_THRESHOLD_ADDR) thr_q <= reg_wdata;
         if (reg_addr == OVFR_DELAY_UNIT_ADDR) unit_q <= reg_wdata;
      end
   end

   // idle level is on, so leaving reset is not taken as an off-to-on edge
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) cmd_on_q <= 1'b1;
      else if (clk_en) cmd_on_q <= output_cmd_on;
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         st_q    <= OVFR_RUN;
         tmr_q   <= '0;
         tries_q <= '0;
      end else if (clk_en) begin
         if (tmr_q != '0) tmr_q <= tmr_q - 1'b1;
         case (st_q)
            OVFR_RUN: begin
               if (ov_now) begin
                  tries_q <= retry;
                  case (resp)
                     OVFR_RESP_IGNORE: st_q <= OVFR_RUN;
                     OVFR_RESP_DELAY: begin
                        st_q  <= OVFR_GRACE;
                        tmr_q <= delay_cycles(dly, unit_q) - 1'b1;
                     end
                     OVFR_RESP_SHUTDOWN: begin
                        st_q  <= (retry == OVFR_RETRY_NONE) ? OVFR_LATCHED
                                                            : OVFR_WAIT;
                        tmr_q <= delay_cycles(dly, unit_q) - 1'b1;
                     end
                     default: st_q <= OVFR_HOLD;
                  endcase
               end
            end
            OVFR_GRACE: begin
               if (tmr_q == '0) begin
                  if (!ov_now) st_q <= OVFR_RUN;
                  else begin
                     st_q  <= (retry == OVFR_RETRY_NONE) ? OVFR_LATCHED : OVFR_WAIT;
                     tmr_q <= delay_cycles(dly, unit_q) - 1'b1;
                  end
               end
            end
            OVFR_WAIT: begin
               if (tmr_q == '0) begin
                  st_q  <= OVFR_RESTART;
                  tmr_q <= delay_cycles(dly, unit_q) - 1'b1;
                  if (tries_q != OVFR_RETRY_FOREVER) tries_q <= tries_q - 1'b1;
               end
            end
            OVFR_RESTART: begin
               // an attempt succeeds once it survives a full spacing interval
               if (ov_now) st_q <= (tries_q == '0) ? OVFR_LATCHED : OVFR_WAIT;
               else if (tmr_q == '0) st_q <= OVFR_RUN;
            end
            OVFR_LATCHED: st_q <= OVFR_LATCHED;
            OVFR_HOLD: if (!ov_now) st_q <= OVFR_RUN;
            default: st_q <= OVFR_RUN;
         endcase
         // retry-forever also stops when another fault shuts the unit down
         if (other_fault_shutdown && st_q != OVFR_RUN) st_q <= OVFR_LATCHED;
         if (clr_any) begin
            st_q  <= OVFR_RUN;
            tmr_q <= '0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         output_enable   <= 1'b0;
         fault_latched   <= 1'b0;
         ov_fault        <= 1'b0;
         reaction_cfg_rd <= OVFR_REACTION_CFG_RESET;
         state_rd        <= OVFR_RUN;
      end else if (clk_en) begin
         output_enable   <= output_cmd_on & (st_q == OVFR_RUN || st_q == OVFR_GRACE
                                             || st_q == OVFR_RESTART);
         fault_latched   <= st_q == OVFR_LATCHED;
         ov_fault        <= ov_now;
         reaction_cfg_rd <= cfg_q;
         state_rd        <= st_q;
      end
   end

   property p_ignore;
      @(posedge clk_sys) disable iff (!rst_b)
      clk_en && st_q == OVFR_RUN && ov_now && resp == OVFR_RESP_IGNORE && !clr_any
      && !other_fault_shutdown |=> st_q == OVFR_RUN;
   endproperty
   a_ignore: assert property (p_ignore) else $error("ignore mode left run");
   property p_shut;
      @(posedge clk_sys) disable iff (!rst_b)
      clk_en && st_q == OVFR_RUN && ov_now && resp == OVFR_RESP_SHUTDOWN && !clr_any
      |=> st_q != OVFR_RUN;
   endproperty
   a_shut: assert property (p_shut) else $error("shutdown mode kept running");
   property p_hold_out;
      @(posedge clk_sys) disable iff (!rst_b) clk_en && st_q == OVFR_HOLD |=> !output_enable;
   endproperty
   a_hold_out: assert property (p_hold_out) else $error("output on while held");
   property p_clear;
      @(posedge clk_sys) disable iff (!rst_b) clk_en && clr_any |=> st_q == OVFR_RUN;
   endproperty
   a_clear: assert property (p_clear) else $error("clear did not release fault");
   property p_latch_stays;
      @(posedge clk_sys) disable iff (!rst_b)
      clk_en && st_q == OVFR_LATCHED && !clr_any |=> st_q == OVFR_LATCHED;
   endproperty
   a_latch_stays: assert property (p_latch_stays) else $error("latched fault left");
   property p_trip;
      @(posedge clk_sys) disable iff (!rst_b) clk_en |=> ov_fault == $past(vout_meas > thr_q);
   endproperty
   a_trip: assert property (p_trip) else $error("trip flag wrong");
   property p_forever;
      @(posedge clk_sys) disable iff (!rst_b)
      clk_en && st_q == OVFR_RESTART && tries_q == OVFR_RETRY_FOREVER && ov_now
      && !clr_any && !other_fault_shutdown |=> st_q == OVFR_WAIT;
   endproperty
   a_forever: assert property (p_forever) else $error("continuous retry stopped");
   property p_exhaust;
      @(posedge clk_sys) disable iff (!rst_b)
      clk_en && st_q == OVFR_RESTART && tries_q == '0 && ov_now && !clr_any
      |=> st_q == OVFR_LATCHED;
   endproperty
   a_exhaust: assert property (p_exhaust) else $error("retries not exhausted");
   property p_grace_on;
      @(posedge clk_sys) disable iff (!rst_b)
      clk_en && st_q == OVFR_GRACE && output_cmd_on |=> output_enable;
   endproperty
   a_grace_on: assert property (p_grace_on) else $error("output dropped in grace delay");
   property p_wait_off;
      @(posedge clk_sys) disable iff (!rst_b) clk_en && st_q == OVFR_WAIT |=> !output_enable;
   endproperty
   a_wait_off: assert property (p_wait_off) else $error("output on while waiting");
   property p_spend;
      @(posedge clk_sys) disable iff (!rst_b)
      clk_en && st_q == OVFR_WAIT && tmr_q == '0 && tries_q != OVFR_RETRY_FOREVER
      |=> tries_q == $past(tries_q) - 3'h1;
   endproperty
   a_spend: assert property (p_spend) else $error("attempt did not spend a retry");
   c_grace: cover property (@(posedge clk_sys) st_q == OVFR_GRACE ##1 st_q == OVFR_WAIT);
   c_retry_ok: cover property (@(posedge clk_sys) st_q == OVFR_RESTART ##1 st_q == OVFR_RUN);
   c_latch: cover property (@(posedge clk_sys) st_q == OVFR_RESTART ##1 st_q == OVFR_LATCHED);
   c_hold: cover property (@(posedge clk_sys) st_q == OVFR_HOLD ##1 st_q == OVFR_RUN);
   c_forever: cover property (@(posedge clk_sys)
      st_q == OVFR_RESTART && tries_q == OVFR_RETRY_FOREVER);
endmodule

// ### sim/ovfr_host_model.sv
// host stand-in for the register side: one-cycle command writes
// assumes writes are taken on the rising clk_sys edge after launch
`timescale 1ns/1ps
module ovfr_host_model (
   input  wire logic        clk_sys,
   output logic             reg_wr,
   output logic [7:0]       reg_addr,
   output logic [15:0]      reg_wdata
);
   initial begin
      reg_wr    = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 16'h0000;
   end
   // released bus shows the inverse so stale data cannot pass for a write
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge clk_sys);
      reg_wr    = 1'b1;
      reg_addr  = a;
      reg_wdata = d;
      @(negedge clk_sys);
      reg_wr    = 1'b0;
      reg_addr  = ~a;
      reg_wdata = ~d;
   endtask
endmodule

// ### sim/ovfr_core_tb.sv
// bench for the over-voltage fault reaction core
// assumes the host model owns register writes; vout and clears driven here
`timescale 1ns/1ps
module ovfr_core_tb;
   import ovfr_pkg::*;
   localparam logic [15:0] HI = 16'h2000;
   localparam logic [15:0] LO = 16'h0800;
   logic        clk_sys = 1'b0;
   logic        rst_b = 1'b0;
   logic        clk_en = 1'b1;
   logic [15:0] vout_meas = LO;
   logic        status_bit_clr = 1'b0, clear_faults_cmd = 1'b0, bias_lost = 1'b0;
   logic        output_cmd_on = 1'b1, other_fault_shutdown = 1'b0;
   logic        reg_wr, output_enable, fault_latched, ov_fault;
   logic [7:0]  reg_addr, reaction_cfg_rd;
   logic [15:0] reg_wdata;
   logic [2:0]  state_rd, prv;
   int          fail_count = 0, cmp_count = 0, n, g;
   always #12.5 clk_sys = ~clk_sys;
   ovfr_host_model u_host (.clk_sys, .reg_wr, .reg_addr, .reg_wdata);
   ovfr_core u_dut (.clk_sys, .rst_b, .clk_en, .reg_wr, .reg_addr, .reg_wdata, .vout_meas,
      .status_bit_clr, .clear_faults_cmd, .bias_lost, .output_cmd_on, .other_fault_shutdown,
      .output_enable, .fault_latched, .ov_fault, .reaction_cfg_rd, .state_rd);
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
      cmp_count++;
      if (s !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge clk_sys);
   endtask
   // bounded wait on enable (w=0) or latch (w=1) reaching level v
   task automatic wt(input bit w, input logic v);
      for (int i = 0; i < 60 && (w ? fault_latched : output_enable) !== v; i++)
         @(negedge clk_sys);
   endtask
   task automatic cfg(input logic [7:0] c);
      u_host.wr(OVFR_REACTION_CFG_ADDR, {8'h00, c});
      cyc(3);
   endtask
   task automatic t_regs;
      chk("reaction_cfg_rd", {8'h00, OVFR_REACTION_CFG_RESET}, {8'h00, reaction_cfg_rd});
      u_host.wr(OVFR_TRIP_THRESHOLD_ADDR, 16'h1000);
      u_host.wr(OVFR_DELAY_UNIT_ADDR, 16'h0002);
      cfg(8'h00);
      clk_en = 1'b0;
      cfg(8'h3f);
      clk_en = 1'b1;
      cyc(2);
      chk("reaction_cfg_rd", 16'h0000, {8'h00, reaction_cfg_rd});
      cfg(8'h3f);
      chk("reaction_cfg_rd", 16'h003f, {8'h00, reaction_cfg_rd});
      u_host.wr(8'h42, 16'h0011);
      cyc(3);
      chk("reaction_cfg_rd", 16'h003f, {8'h00, reaction_cfg_rd});
      $display("t_regs done");
   endtask
   task automatic t_modes;
      vout_meas = HI;
      cyc(10);
      chk("ov_fault", 1, ov_fault);
      chk("output_enable", 1, output_enable);
      vout_meas = LO;
      cfg(8'hc0);
      vout_meas = HI;
      wt(0, 0);
      chk("output_enable", 0, output_enable);
      vout_meas = LO;
      wt(0, 1);
      chk("output_enable", 1, output_enable);
      $display("t_modes done");
   endtask
   task automatic t_clears;
      for (int i = 0; i < 5; i++) begin
         cfg(8'h80);
         vout_meas = HI;
         cyc(5);
         chk("output_enable", 0, output_enable);
         vout_meas = LO;
         cyc(20);
         chk("fault_latched", 1, fault_latched);
         status_bit_clr = (i == 0);
         clear_faults_cmd = (i == 1);
         bias_lost = (i == 2);
         output_cmd_on = (i != 3);
         rst_b = (i != 4);
         cyc(1);
         {status_bit_clr, clear_faults_cmd, bias_lost, output_cmd_on, rst_b} = 5'h03;
         wt(0, 1);
         chk("output_enable", 1, output_enable);
      end
      // the reset case put threshold and unit back to their defaults
      u_host.wr(OVFR_TRIP_THRESHOLD_ADDR, 16'h1000);
      u_host.wr(OVFR_DELAY_UNIT_ADDR, 16'h0002);
      $display("t_clears done");
   endtask
   task automatic t_retry;
      cfg(8'h51);
      chk("reaction_cfg_rd", 16'h0051, {8'h00, reaction_cfg_rd});
      vout_meas = HI;
      n = 0;
      g = 0;
      for (int i = 0; i < 300 && fault_latched !== 1'b1; i++) begin
         prv = state_rd;
         @(negedge clk_sys);
         if (i == 3) chk("output_enable", 1, output_enable);
         g += int'(state_rd === OVFR_GRACE);
         n += int'(state_rd === OVFR_RESTART && prv !== OVFR_RESTART);
      end
      chk("grace cycles", 4, g[15:0]);
      chk("restarts", 2, n[15:0]);
      vout_meas = LO;
      $display("t_retry done");
   endtask
   task automatic t_forever;
      clear_faults_cmd = 1'b1;
      cfg(8'hb8);
      clear_faults_cmd = 1'b0;
      vout_meas = HI;
      cyc(200);
      chk("fault_latched", 0, fault_latched);
      for (int i = 0; i < 20 && state_rd !== OVFR_RESTART; i++) @(negedge clk_sys);
      n = 1;
      @(negedge clk_sys);
      while (state_rd !== OVFR_RESTART && n < 300) begin
         @(negedge clk_sys);
         n++;
      end
      chk("restart spacing", 16'h0002, n[15:0]);
      other_fault_shutdown = 1'b1;
      wt(1, 1);
      chk("fault_latched", 1, fault_latched);
      other_fault_shutdown = 1'b0;
      vout_meas = LO;
      $display("t_forever done");
   endtask
   task automatic complete_run;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      cyc(4);
      rst_b = 1'b1;
      t_regs;
      t_modes;
      t_clears;
      t_retry;
      t_forever;
      complete_run;
   end
   initial begin
      cyc(6000);
      fail_count++;
      complete_run;
   end
endmodule
